// *** hpp_pkg.sv ***
package hpp_pkg;
	localparam int DATA_W = 24;
	localparam int ADDR_W = 4;
	// Register word offsets (byte address = 4 * index)
	localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] REG_PORT0 = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PORT1 = 4'h2;
	localparam logic [ADDR_W-1:0] REG_PORT2 = 4'h3;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] REG_EVENT = 4'h5;
	// Configuration fields
	localparam int CFG_WIDTH_LO = 0;
	localparam int CFG_WIDTH_HI = 1;
	localparam int CFG_DREADY = 2;
	localparam int CFG_LEMPTY = 3;
	localparam int CFG_DPOL = 4;
	localparam int CFG_LPOL = 5;
	localparam logic [7:0] CFG_RW_MASK = 8'h33;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Control register fields
	localparam int CTRL_EN = 0;
	// Event register fields
	localparam int EVT_RD_DONE = 0;
	localparam int EVT_WR_DONE = 1;
	// Transfer width codes
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_24 = 2'h2;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

	typedef struct packed {
		logic strobe_n;
		logic oe_n;
		logic cs_n;
	} hpp_host_ctl_t;

	typedef struct packed {
		logic room_available_pin;
		logic data_available_pin;
	} hpp_status_pins_t;
endpackage : hpp_pkg

// *** hpp_port.sv ***
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module hpp_port (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire hpp_pkg::hpp_host_ctl_t host_ctl_in,
	input wire logic [23:0] host_data_in,
	output logic [23:0] host_data_out,
	output logic [23:0] host_data_oe,
	output hpp_pkg::hpp_status_pins_t status_pins,
	output logic [1:0] status_pins_oe,
	output logic port_override,
	output logic port_irq
);
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] prev_q;
	logic [7:0] cfg_q;
	logic en_q;
	logic dready_q;
	logic lempty_q;
	logic [23:0] out_latch_q;
	logic [23:0] in_latch_q;
	logic [1:0] evt_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic strobe_act, oe_act, cs_act;
	logic strobe_fall, strobe_rise, oe_fall, oe_rise;
	logic strobe_was_act, oe_was_act;
	logic [23:0] data_sync1_q;
	logic [23:0] data_sync2_q;
	logic req, wr_acc, rd_acc;
	logic [1:0] width;
	logic [23:0] width_mask;
	logic [7:0] cfg_view;
	logic [7:0] be_mask;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			prev_q <= 3'h7;
			data_sync1_q <= 24'h000000;
			data_sync2_q <= 24'h000000;
		end else if (clk_en) begin
			sync1_q <= host_ctl_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			data_sync1_q <= host_data_in;
			data_sync2_q <= data_sync1_q;
		end
	end

	assign cs_act = ~sync2_q[0] & en_q;
	assign strobe_act = ~sync2_q[2] & cs_act;
	assign oe_act = ~sync2_q[1] & cs_act;
	// gated edges, select may fall together
	assign strobe_was_act = ~prev_q[2] & ~prev_q[0];
	assign oe_was_act = ~prev_q[1] & ~prev_q[0];
	assign strobe_fall = strobe_act & ~strobe_was_act;
	assign strobe_rise = sync2_q[2] & ~prev_q[2] & ~prev_q[0] & en_q;
	assign oe_fall = oe_act & ~oe_was_act;
	assign oe_rise = sync2_q[1] & ~prev_q[1] & ~prev_q[0] & en_q;

	// Bus: one wait cycle, answer on the following edge
	assign req = (avs_read | avs_write) & clk_en;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_acc = avs_write & ack_q & clk_en;
	assign rd_acc = avs_read & ack_q & clk_en;
	assign be_mask = avs_byteenable[0] ? 8'hFF : 8'h00;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else if (clk_en) begin
			ack_q <= req & ~ack_q;
		end
	end

	assign width = cfg_q[hpp_pkg::CFG_WIDTH_HI:hpp_pkg::CFG_WIDTH_LO];
	always_comb begin
		case (width)
			hpp_pkg::WIDTH_8: width_mask = 24'h0000FF;
			hpp_pkg::WIDTH_16: width_mask = 24'h00FFFF;
			default: width_mask = 24'hFFFFFF;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= hpp_pkg::CFG_RESET;
			en_q <= 1'b0;
		end else if (wr_acc) begin
			if (avs_address == hpp_pkg::REG_CFG) begin
				cfg_q <= (cfg_q & ~(hpp_pkg::CFG_RW_MASK & be_mask)) |
					(avs_writedata[7:0] & hpp_pkg::CFG_RW_MASK & be_mask);
			end
			if (avs_address == hpp_pkg::REG_CTRL && avs_byteenable[0]) begin
				en_q <= avs_writedata[hpp_pkg::CTRL_EN];
			end
		end
	end

	// Firmware output latches, one byte per port
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_latch_q <= 24'h000000;
		end else if (wr_acc && avs_byteenable[0]) begin
			case (avs_address)
				hpp_pkg::REG_PORT0: out_latch_q[7:0] <= avs_writedata[7:0];
				hpp_pkg::REG_PORT1: out_latch_q[15:8] <= avs_writedata[7:0];
				hpp_pkg::REG_PORT2: out_latch_q[23:16] <= avs_writedata[7:0];
				default: out_latch_q <= out_latch_q;
			endcase
		end
	end

	// Data-ready: set wins over host clear
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dready_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_acc && avs_address == hpp_pkg::REG_PORT0) begin
				dready_q <= 1'b1;
			end else if (oe_fall) begin
				dready_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lempty_q <= 1'b1;
			in_latch_q <= 24'h000000;
		end else if (clk_en) begin
			if (strobe_act) begin
				in_latch_q <= data_sync2_q & width_mask;
			end
			if (strobe_fall) begin
				lempty_q <= 1'b0;
			end else if (rd_acc && avs_address == hpp_pkg::REG_PORT0) begin
				lempty_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			evt_q <= 2'h0;
		end else if (clk_en) begin
			evt_q[hpp_pkg::EVT_RD_DONE] <= oe_rise |
				(evt_q[hpp_pkg::EVT_RD_DONE] &
				~(wr_acc && avs_address == hpp_pkg::REG_EVENT &&
				avs_writedata[hpp_pkg::EVT_RD_DONE]));
			evt_q[hpp_pkg::EVT_WR_DONE] <= strobe_rise |
				(evt_q[hpp_pkg::EVT_WR_DONE] &
				~(wr_acc && avs_address == hpp_pkg::REG_EVENT &&
				avs_writedata[hpp_pkg::EVT_WR_DONE]));
		end
	end
	assign port_irq = |evt_q;

	always_comb begin
		cfg_view = cfg_q;
		cfg_view[hpp_pkg::CFG_DREADY] = ~status_pins.data_available_pin;
		cfg_view[hpp_pkg::CFG_LEMPTY] = ~status_pins.room_available_pin;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (req && !ack_q && avs_read) begin
			case (avs_address)
				hpp_pkg::REG_CFG: rdata_q <= {24'h000000, cfg_view};
				hpp_pkg::REG_PORT0: rdata_q <= {24'h000000, in_latch_q[7:0]};
				hpp_pkg::REG_PORT1: rdata_q <= {24'h000000, in_latch_q[15:8]};
				hpp_pkg::REG_PORT2:
					rdata_q <= {24'h000000, in_latch_q[23:16]};
				hpp_pkg::REG_CTRL: rdata_q <= {31'h00000000, en_q};
				hpp_pkg::REG_EVENT: rdata_q <= {30'h00000000, evt_q};
				default: rdata_q <= hpp_pkg::UNMAPPED_DATA;
			endcase
		end
	end
	assign avs_readdata = rdata_q;

	always_comb begin
		status_pins.data_available_pin = cfg_q[hpp_pkg::CFG_DPOL] ?
			~dready_q : dready_q;
		status_pins.room_available_pin = cfg_q[hpp_pkg::CFG_LPOL] ?
			~lempty_q : lempty_q;
	end

	assign port_override = en_q;
	assign status_pins_oe = {en_q, en_q};
	// drive word while oe and select low
	assign host_data_oe = (oe_act ? 24'hFFFFFF : 24'h000000) & width_mask;
	assign host_data_out = out_latch_q & width_mask;
endmodule : hpp_port

// *** hpp_port_props.sv ***
`timescale 1ns/1ps
module hpp_port_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire hpp_pkg::hpp_host_ctl_t host_ctl_in,
	input wire logic [23:0] host_data_oe,
	input wire hpp_pkg::hpp_status_pins_t status_pins,
	input wire logic [1:0] status_pins_oe,
	input wire logic port_override,
	input wire logic port_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset || !clk_en);
	property p_pin_oe;
		status_pins_oe == {2{port_override}};
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("pin enable");
	property p_gate_out;
		host_ctl_in.cs_n [*4] |-> host_data_oe == 24'h000000;
	endproperty
	a_gate_out: assert property (p_gate_out) else $error("drive");
	property p_drive;
		port_override && !host_ctl_in.oe_n && !host_ctl_in.cs_n [*4]
			|-> host_data_oe[7:0] == 8'hFF;
	endproperty
	a_drive: assert property (p_drive) else $error("no drive");
	property p_gate_irq;
		host_ctl_in.cs_n [*5] |=> !$rose(port_irq);
	endproperty
	a_gate_irq: assert property (p_gate_irq) else $error("irq");
	property p_irq_oe;
		port_override && $rose(host_ctl_in.oe_n) && !host_ctl_in.cs_n
			|-> ##[1:6] port_irq;
	endproperty
	a_irq_oe: assert property (p_irq_oe) else $error("read irq");
	property p_irq_stb;
		port_override && $rose(host_ctl_in.strobe_n) && !host_ctl_in.cs_n
			|-> ##[1:6] port_irq;
	endproperty
	a_irq_stb: assert property (p_irq_stb) else $error("write irq");
	property p_sync;
		$rose(host_ctl_in.strobe_n) && !port_irq |=> !port_irq;
	endproperty
	a_sync: assert property (p_sync) else $error("early irq");
	property p_inv;
		avs_read && !avs_waitrequest && avs_address == hpp_pkg::REG_CFG
			|-> avs_readdata[3:2] == ~status_pins;
	endproperty
	a_inv: assert property (p_inv) else $error("status");
endmodule : hpp_port_props
bind hpp_port hpp_port_props i_hpp_port_props (.sys_clk, .reset, .clk_en,
	.avs_address, .avs_read, .avs_readdata, .avs_waitrequest, .host_ctl_in,
	.host_data_oe, .status_pins, .status_pins_oe, .port_override, .port_irq);

// *** hpp_host_model.sv ***
`timescale 1ns/1ps
module hpp_host_model (
	input wire logic sys_clk,
	output hpp_pkg::hpp_host_ctl_t ctl,
	output logic [23:0] data,
	input wire logic [23:0] q,
	input wire logic [23:0] q_oe
);
	initial begin
		ctl = 3'h7;
		data = 24'h5A5A5A;
	end
	task automatic put(input logic [23:0] d);
		data <= d;
		ctl <= 3'h2;
		repeat (5) @(posedge sys_clk);
		ctl <= 3'h6;
		repeat (4) @(posedge sys_clk);
		ctl <= 3'h7;
		data <= ~d;
		@(posedge sys_clk);
	endtask : put
	task automatic get(input logic sel, output logic [23:0] v);
		ctl <= {1'h1, 1'h0, ~sel};
		repeat (5) @(posedge sys_clk);
		v = q & q_oe;
		ctl <= {1'h1, 1'h1, ~sel};
		repeat (4) @(posedge sys_clk);
		ctl <= 3'h7;
		@(posedge sys_clk);
	endtask : get
endmodule : hpp_host_model

// *** tb_parallel_host_latch_port.sv ***
`timescale 1ns/1ps
module tb_parallel_host_latch_port;
	logic sys_clk, reset, clk_en, avs_read, avs_write, avs_waitrequest;
	logic port_override, port_irq, dr, le, pd, pl;
	logic [1:0] w, status_pins_oe;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [23:0] host_data_in, host_data_out, host_data_oe, v, u, m, q;
	hpp_pkg::hpp_host_ctl_t host_ctl_in;
	hpp_pkg::hpp_status_pins_t status_pins;
	int errors, n_checks, cyc;
	hpp_port i_hpp_port (.sys_clk, .reset, .clk_en, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
		.avs_readdata, .avs_waitrequest, .host_ctl_in, .host_data_in,
		.host_data_out, .host_data_oe, .status_pins, .status_pins_oe,
		.port_override, .port_irq);
	hpp_host_model i_hpp_host_model (.sys_clk, .ctl(host_ctl_in),
		.data(host_data_in), .q(host_data_out), .q_oe(host_data_oe));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
		r = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge sys_clk);
	endtask : bus
	task automatic pins();
		chk(status_pins, {le ^ pl, dr ^ pd});
		bus(hpp_pkg::REG_CFG, 1'h0, 0);
		chk(r, {2'h0, pl, pd, ~(le ^ pl), ~(dr ^ pd), w});
	endtask : pins
	task automatic conclude();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		{reset, dr, le, pd, pl, w} = 7'h50;
		clk_en = 1'h1;
		{avs_read, avs_write, avs_address, avs_writedata} = 0;
		{errors, n_checks, cyc} = 0;
		void'($urandom(18));
		repeat (10) @(posedge sys_clk);
		reset <= 1'h0;
		@(posedge sys_clk);
		pins();
		bus(4'hF, 1'h0, 0);
		chk(r, hpp_pkg::UNMAPPED_DATA);
		bus(hpp_pkg::REG_CTRL, 1'h1, 1);
		chk({port_override, status_pins_oe}, 3'h7);
		for (int k = 0; k < 4; k++) begin
			w = 2'(k);
			{pd, pl} = 2'($urandom);
			v = 24'($urandom);
			m = w == 0 ? 24'hFF : w == 1 ? 24'hFFFF : 24'hFFFFFF;
			bus(hpp_pkg::REG_CFG, 1'h1, {26'h0, pl, pd, 2'h3, w});
			bus(hpp_pkg::REG_PORT2, 1'h1, v[23:16]);
			bus(hpp_pkg::REG_PORT1, 1'h1, v[15:8]);
			pins();
			bus(hpp_pkg::REG_PORT0, 1'h1, v[7:0]);
			dr = 1'h1;
			pins();
			i_hpp_host_model.get(1'h0, q);
			chk({q, port_irq}, 0);
			i_hpp_host_model.get(1'h1, q);
			dr = 1'h0;
			chk({q, port_irq}, {v & m, 1'h1});
			pins();
			bus(hpp_pkg::REG_EVENT, 1'h0, 0);
			chk(r, 1 << hpp_pkg::EVT_RD_DONE);
			bus(hpp_pkg::REG_EVENT, 1'h1, 3);
			u = ~v & m;
			i_hpp_host_model.put(~v);
			le = 1'h0;
			chk(port_irq, 1'h1);
			pins();
			bus(hpp_pkg::REG_EVENT, 1'h0, 0);
			chk(r, 1 << hpp_pkg::EVT_WR_DONE);
			bus(hpp_pkg::REG_EVENT, 1'h1, 3);
			bus(hpp_pkg::REG_PORT2, 1'h0, 0);
			chk(r, u[23:16]);
			bus(hpp_pkg::REG_PORT1, 1'h0, 0);
			chk(r, u[15:8]);
			pins();
			bus(hpp_pkg::REG_PORT0, 1'h0, 0);
			chk(r, u[7:0]);
			le = 1'h1;
			pins();
		end
		clk_en <= 1'h0;
		i_hpp_host_model.put(24'h3C3C3C);
		clk_en <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk(port_irq, 1'h0);
		pins();
		conclude();
	end
endmodule : tb_parallel_host_latch_port
